// File: verilog/pdaf_override.sv
// Port D alternate-function override: pin direction, value and pull-up.
`timescale 1ns/1ps
`default_nettype none
`include "pdaf_map.svh"

module pdaf_override #(
    parameter int                 CLK_DIV = `PDAF_CLK_DIV,
    parameter int                 DIV_W   = `PDAF_DIV_W
) (
    // Clock and resets
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             porRst,
    // Port registers
    input  wire pdaf_pkg::pdaf_pin_t directionBits,
    input  wire pdaf_pkg::pdaf_pin_t outBits,
    input  wire logic             pullUpDisable,
    // LIN/UART
    input  wire logic             uartRxEnable,
    input  wire logic             uartTxEnable,
    input  wire logic             uartTxData,
    // SPI on alternate pins
    input  wire logic             spiEnable,
    input  wire logic             spiMaster,
    input  wire logic             spiAltPins,
    input  wire logic             spiMasterOutData,
    input  wire logic             spiClockOut,
    input  wire logic             spiSlaveOutData,
    // Timers
    input  wire logic             timer0CompareEnable,
    input  wire logic             timer0CompareAOut,
    input  wire logic             timer1CompareEnable,
    input  wire logic             timer1CompareAOut,
    // Power stage controller
    input  wire logic             powerStageEnable0a,
    input  wire logic             powerStageOut0a,
    // Clock output fuse
    input  wire logic             clockOutputFuse,
    // Pins
    input  wire pdaf_pkg::pdaf_pin_t pinIn,
    output var  pdaf_pkg::pdaf_pin_t pinDrive,
    output var  pdaf_pkg::pdaf_pin_t pinOeN,
    output var  pdaf_pkg::pdaf_pin_t pullUpEnable,
    // Synchronised pin values to peripherals
    output var  pdaf_pkg::pdaf_pin_t pinValue,
    output var  pdaf_pkg::pdaf_pin_t pinChangeIrq,
    output var  logic             externalInterruptZero,
    output var  logic             timer1CaptureIn,
    output var  logic             uartRxData,
    output var  logic             spiSlaveSelectN,
    output var  logic             spiSlaveActive,
    output var  logic             spiMasterOutIn,
    output var  logic             spiClockIn,
    output var  logic             spiMasterIn,
    output var  logic             powerStageIn0,
    output var  logic             powerStageIn2
);
    import pdaf_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Port-register pull-up: input direction, output bit one, not disabled.
    function automatic logic portPullUp(input logic dirBit,
                                        input logic outBit,
                                        input logic pud);
        portPullUp = ~dirBit & outBit & ~pud;
    endfunction

    // Pull-up of a pin that a peripheral has forced to input.
    function automatic logic forcedPullUp(input logic outBit,
                                          input logic pud);
        forcedPullUp = outBit & ~pud;
    endfunction

    // ------------------------------------------------------------------
    // Peripheral mode decode
    // ------------------------------------------------------------------
    wire logic spiAltOn     = spiEnable & spiAltPins;
    wire logic spiAltSlave  = spiAltOn & ~spiMaster;
    wire logic spiAltMaster = spiAltOn & spiMaster;

    // ------------------------------------------------------------------
    // Pin 4: UART receive, SPI clock, capture
    // ------------------------------------------------------------------
    wire logic p4Forced = uartRxEnable | spiAltSlave;
    wire logic p4Dir    = p4Forced ? 1'b0
                                   : directionBits[`PDAF_PIN_RX];
    wire logic p4Val    = (spiAltMaster & ~uartRxEnable)
                        ? spiClockOut : outBits[`PDAF_PIN_RX];
    wire logic p4Pu     = p4Forced
                        ? forcedPullUp(outBits[`PDAF_PIN_RX], pullUpDisable)
                        : portPullUp(directionBits[`PDAF_PIN_RX],
                                     outBits[`PDAF_PIN_RX], pullUpDisable);

    // ------------------------------------------------------------------
    // Pin 3: UART transmit, timer 0 compare A, SPI select and master-out
    // ------------------------------------------------------------------
    // The transmitter wins over the SPI so a running frame is never cut.
    wire logic p3Tx     = uartTxEnable;
    wire logic p3SpiIn  = ~p3Tx & spiAltSlave;
    wire logic p3SpiOut = ~p3Tx & spiAltMaster;
    wire logic p3Timer  = ~p3Tx & ~spiAltOn & timer0CompareEnable;
    wire logic p3Dir    = p3Tx    ? 1'b1
                        : p3SpiIn ? 1'b0
                        : directionBits[`PDAF_PIN_TX];
    wire logic p3Val    = p3Tx     ? uartTxData
                        : p3SpiOut ? spiMasterOutData
                        : p3Timer  ? timer0CompareAOut
                        : outBits[`PDAF_PIN_TX];
    wire logic p3Pu     = p3Tx ? 1'b0
                        : p3SpiIn
                        ? forcedPullUp(outBits[`PDAF_PIN_TX], pullUpDisable)
                        : portPullUp(directionBits[`PDAF_PIN_TX],
                                     outBits[`PDAF_PIN_TX], pullUpDisable);

    // ------------------------------------------------------------------
    // Pin 2: SPI master-in, timer 1 compare A
    // ------------------------------------------------------------------
    wire logic p2SpiIn  = spiAltMaster;
    wire logic p2SpiOut = spiAltSlave;
    wire logic p2Timer  = ~spiAltOn & timer1CompareEnable;
    wire logic p2Dir    = p2SpiIn ? 1'b0
                                  : directionBits[`PDAF_PIN_MISO];
    wire logic p2Val    = p2SpiOut ? spiSlaveOutData
                        : p2Timer  ? timer1CompareAOut
                        : outBits[`PDAF_PIN_MISO];
    wire logic p2Pu     = p2SpiIn
                        ? forcedPullUp(outBits[`PDAF_PIN_MISO], pullUpDisable)
                        : portPullUp(directionBits[`PDAF_PIN_MISO],
                                     outBits[`PDAF_PIN_MISO], pullUpDisable);

    // ------------------------------------------------------------------
    // Pin 0: power stage output 0A
    // ------------------------------------------------------------------
    wire logic p0Dir    = powerStageEnable0a
                        | directionBits[`PDAF_PIN_PSC0A];
    wire logic p0Val    = powerStageEnable0a ? powerStageOut0a
                                             : outBits[`PDAF_PIN_PSC0A];
    wire logic p0Pu     = ~powerStageEnable0a
                        & portPullUp(directionBits[`PDAF_PIN_PSC0A],
                                     outBits[`PDAF_PIN_PSC0A], pullUpDisable);

    // ------------------------------------------------------------------
    // Combined next values for every pin; pin 1 uses its lane only as a fallback
    // ------------------------------------------------------------------
    pdaf_pin_t dirNxt;
    pdaf_pin_t valNxt;
    pdaf_pin_t puNxt;

    genvar g;
    generate
        for (g = 0; g < `PDAF_PORT_W; g++) begin : gPin
            if (g == `PDAF_PIN_PSC0A) begin : gP0
                assign dirNxt[g] = p0Dir;
                assign valNxt[g] = p0Val;
                assign puNxt[g]  = p0Pu;
            end else if (g == `PDAF_PIN_MISO) begin : gP2
                assign dirNxt[g] = p2Dir;
                assign valNxt[g] = p2Val;
                assign puNxt[g]  = p2Pu;
            end else if (g == `PDAF_PIN_TX) begin : gP3
                assign dirNxt[g] = p3Dir;
                assign valNxt[g] = p3Val;
                assign puNxt[g]  = p3Pu;
            end else if (g == `PDAF_PIN_RX) begin : gP4
                assign dirNxt[g] = p4Dir;
                assign valNxt[g] = p4Val;
                assign puNxt[g]  = p4Pu;
            end else begin : gPlain
                // Pins 1, 5, 6 and 7 carry the plain port function; pin 1 is produced
                // separately and uses its lane only as the fuse-off fallback.
                assign dirNxt[g] = directionBits[g];
                assign valNxt[g] = outBits[g];
                assign puNxt[g]  = portPullUp(directionBits[g], outBits[g],
                                              pullUpDisable);
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Pin registers on the system reset
    // ------------------------------------------------------------------
    // During reset every pin but pin 1 floats as an input with no pull-up.
    pdaf_pin_t drive_r;
    pdaf_pin_t oeN_r;
    pdaf_pin_t pu_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drive_r <= `PDAF_RST_BYTE;
            oeN_r   <= `PDAF_RST_ONES;
            pu_r    <= `PDAF_RST_BYTE;
        end else begin
            drive_r <= valNxt;
            oeN_r   <= ~dirNxt;
            pu_r    <= puNxt;
        end
    end

    // ------------------------------------------------------------------
    // Clock output divider on the power-on reset
    // ------------------------------------------------------------------
    // The divider, and pin 1 while the fuse is set, hang on the power-on reset
    // alone, so the divided clock keeps running while the system reset is held.
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CLK_DIV - 1);

    logic [DIV_W-1:0] divCnt_r;
    logic             divTick;
    logic             divClk_r;
    logic             clkDrive_r;
    logic             clkOeN_r;
    logic             clkPu_r;

    assign divTick = (divCnt_r == DIV_LAST);

    always_ff @(posedge clk or posedge porRst) begin
        if (porRst) begin
            divCnt_r <= '0;
            divClk_r <= 1'b0;
        end else begin
            divCnt_r <= divTick ? '0 : divCnt_r + 1'b1;
            divClk_r <= divClk_r ^ divTick;
        end
    end

    wire logic divClkNxt = divClk_r ^ divTick;
    wire logic p1Fuse    = clockOutputFuse;
    wire logic p1Idle    = ~p1Fuse & rst;

    always_ff @(posedge clk or posedge porRst) begin
        if (porRst) begin
            clkDrive_r <= 1'b0;
            clkOeN_r   <= 1'b1;
            clkPu_r    <= 1'b0;
        end else if (p1Fuse) begin
            clkDrive_r <= divClkNxt;
            clkOeN_r   <= 1'b0;
            clkPu_r    <= 1'b0;
        end else if (p1Idle) begin
            clkDrive_r <= 1'b0;
            clkOeN_r   <= 1'b1;
            clkPu_r    <= 1'b0;
        end else begin
            clkDrive_r <= valNxt[`PDAF_PIN_DIVCLK];
            clkOeN_r   <= ~dirNxt[`PDAF_PIN_DIVCLK];
            clkPu_r    <= puNxt[`PDAF_PIN_DIVCLK];
        end
    end

    assign pinDrive = {drive_r[7:2], clkDrive_r, drive_r[0]};
    assign pinOeN   = {oeN_r[7:2], clkOeN_r, oeN_r[0]};
    // Comparator pins get no pull-up if their out bits are clear, their direction bits are set or pullUpDisable is set.
    assign pullUpEnable = {pu_r[7:2], clkPu_r, pu_r[0]};

    // ------------------------------------------------------------------
    // Input path
    // ------------------------------------------------------------------
    pdaf_pin_t syncPins;

    pdaf_sync #(
        .WIDTH   (`PDAF_PORT_W),
        .RST_VAL (`PDAF_RST_BYTE)
    ) uSync (
        .clk     (clk),
        .rst     (rst),
        .asyncIn (pinIn),
        .syncOut (syncPins)
    );

    // Peripheral inputs are held in flops so each output has a clean
    // source; this adds one cycle after the filter.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinValue              <= `PDAF_RST_BYTE;
            pinChangeIrq          <= `PDAF_RST_BYTE;
            externalInterruptZero <= 1'b0;
            timer1CaptureIn       <= 1'b0;
            uartRxData            <= 1'b1;
            spiSlaveSelectN       <= 1'b1;
            spiSlaveActive        <= 1'b0;
            spiMasterOutIn        <= 1'b0;
            spiClockIn            <= 1'b0;
            spiMasterIn           <= 1'b0;
            powerStageIn0         <= 1'b0;
            powerStageIn2         <= 1'b0;
        end else begin
            pinValue              <= syncPins;
            // Bit i here is pin-change interrupt PDAF_PCINT_BASE plus i.
            pinChangeIrq          <= syncPins;
            externalInterruptZero <= syncPins[`PDAF_PIN_EXTIRQ];
            timer1CaptureIn       <= syncPins[`PDAF_PIN_RX];
            uartRxData            <= syncPins[`PDAF_PIN_RX];
            spiSlaveSelectN       <= syncPins[`PDAF_PIN_TX];
            spiSlaveActive        <= spiAltSlave
                                   & ~syncPins[`PDAF_PIN_TX];
            spiMasterOutIn        <= syncPins[`PDAF_PIN_TX];
            spiClockIn            <= syncPins[`PDAF_PIN_RX];
            spiMasterIn           <= syncPins[`PDAF_PIN_MISO];
            powerStageIn0         <= syncPins[`PDAF_PIN_DIVCLK];
            powerStageIn2         <= syncPins[`PDAF_PIN_MISO];
        end
    end

endmodule

`default_nettype wire

// File: verilog/pdaf_map.svh
// Constants for the port D alternate-function override block.
`ifndef PDAF_MAP_SVH
`define PDAF_MAP_SVH

// ------------------------------------------------------------------
// Pin positions
// ------------------------------------------------------------------
`define PDAF_PIN_PSC0A   0
`define PDAF_PIN_DIVCLK  1
`define PDAF_PIN_MISO    2
`define PDAF_PIN_TX      3
`define PDAF_PIN_RX      4
`define PDAF_PIN_EXTIRQ  6

// ------------------------------------------------------------------
// Widths, reset values and counts
// ------------------------------------------------------------------
`define PDAF_PORT_W      8
`define PDAF_PCINT_BASE  16
`define PDAF_CLK_DIV     2
`define PDAF_DIV_W       8
`define PDAF_RST_BYTE    8'h00
`define PDAF_RST_ONES    8'hFF

`endif

// File: verilog/pdaf_pkg.sv
// Types shared by the port D alternate-function override block.
`default_nettype none
`include "pdaf_map.svh"

package pdaf_pkg;
    typedef logic [`PDAF_PORT_W-1:0] pdaf_pin_t;
endpackage

`default_nettype wire

// File: verilog/pdaf_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none

module pdaf_sync #(
    parameter int          WIDTH   = 8,
    parameter logic [7:0]  RST_VAL = 8'h00
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Asynchronous inputs
    input  wire logic [WIDTH-1:0] asyncIn,
    // Filtered outputs
    output var  logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    // ------------------------------------------------------------------
    // Synchroniser chain
    // ------------------------------------------------------------------
    // The first stage feeds only the second, so a metastable value never
    // reaches the agreement compare.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_r <= RST_VAL[WIDTH-1:0];
            stage2_r <= RST_VAL[WIDTH-1:0];
            stage3_r <= RST_VAL[WIDTH-1:0];
        end else begin
            stage1_r <= asyncIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // ------------------------------------------------------------------
    // Agreement filter
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gFilt
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    syncOut[i] <= RST_VAL[i];
                end else if (stage2_r[i] == stage3_r[i]) begin
                    syncOut[i] <= stage3_r[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// File: tb/pdaf_override_chk.sv
// Concurrent checks on the port D alternate-function override ports.
`timescale 1ns/1ps
`default_nettype none

module pdaf_override_chk #(
    parameter int CLK_DIV = 2
) (
    // Clock and resets
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                porRst,
    // Port registers and peripheral controls
    input wire pdaf_pkg::pdaf_pin_t directionBits,
    input wire pdaf_pkg::pdaf_pin_t outBits,
    input wire logic                pullUpDisable,
    input wire logic                uartRxEnable,
    input wire logic                uartTxEnable,
    input wire logic                uartTxData,
    input wire logic                spiEnable,
    input wire logic                spiMaster,
    input wire logic                spiAltPins,
    input wire logic                timer0CompareEnable,
    input wire logic                timer0CompareAOut,
    input wire logic                timer1CompareEnable,
    input wire logic                timer1CompareAOut,
    input wire logic                powerStageEnable0a,
    input wire logic                powerStageOut0a,
    input wire logic                clockOutputFuse,
    // Pins and forwarded levels
    input wire pdaf_pkg::pdaf_pin_t pinIn,
    input wire pdaf_pkg::pdaf_pin_t pinDrive,
    input wire pdaf_pkg::pdaf_pin_t pinOeN,
    input wire pdaf_pkg::pdaf_pin_t pullUpEnable,
    input wire pdaf_pkg::pdaf_pin_t pinChangeIrq,
    input wire logic                externalInterruptZero,
    input wire logic                timer1CaptureIn,
    input wire logic                powerStageIn0,
    input wire logic                powerStageIn2
);
    import pdaf_pkg::*;

    // ----------------------------------------------------------------
    // Clock output run-length tracking
    // ----------------------------------------------------------------
    // Of the two resets, only the power-on reset clears these, because the divided clock
    // must keep running through an ordinary reset.
    logic [7:0] warm_r;
    logic [7:0] runLen_r;
    logic       prevDrive_r;
    logic       settled;
    logic       altOn;
    logic       pud;
    assign settled = warm_r >= 8'(4 * CLK_DIV);
    assign altOn = spiEnable && spiAltPins;
    assign pud = pullUpDisable;
    always_ff @(posedge clk or posedge porRst) begin
        if (porRst) begin
            warm_r <= 8'h00;
            runLen_r <= 8'h00;
            prevDrive_r <= 1'b0;
        end else begin
            warm_r <= !clockOutputFuse ? 8'h00 :
                      (warm_r == 8'hFF) ? warm_r : warm_r + 8'h01;
            prevDrive_r <= pinDrive[1];
            runLen_r <= (pinDrive[1] != prevDrive_r) ? 8'h01
                                                     : runLen_r + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence pinsQuiet;
        (pinIn == $past(pinIn))[*6];
    endsequence

    rx_forces_input_a: assert property (
        uartRxEnable |=> pinOeN[4] &&
        pullUpEnable[4] == ($past(outBits[4]) && !$past(pud)))
        else $error("receive pin not held as input");
    tx_forces_out_a: assert property (
        uartTxEnable |=> !pinOeN[3] && !pullUpEnable[3] &&
        pinDrive[3] == $past(uartTxData))
        else $error("transmit pin not driving data");
    t0_needs_dir_a: assert property (
        !uartTxEnable && !altOn && timer0CompareEnable |=>
        pinOeN[3] == !$past(directionBits[3]) &&
        (pinOeN[3] || pinDrive[3] == $past(timer0CompareAOut)))
        else $error("timer 0 output ignores direction");
    slave_inputs_a: assert property (
        altOn && !spiMaster && !uartTxEnable |=> pinOeN[3] && pinOeN[4] &&
        pullUpEnable[4:3] == ($past(outBits[4:3]) & {2{!$past(pud)}}))
        else $error("slave pins not forced to input");
    master_in_a: assert property (
        altOn && spiMaster |=> pinOeN[2] &&
        pullUpEnable[2] == ($past(outBits[2]) && !$past(pud)))
        else $error("master input pin not forced to input");
    t1_needs_dir_a: assert property (
        !altOn && timer1CompareEnable |=>
        pinOeN[2] == !$past(directionBits[2]) &&
        (pinOeN[2] || pinDrive[2] == $past(timer1CompareAOut)))
        else $error("timer 1 output ignores direction");
    divclk_driven_a: assert property (
        @(posedge clk) disable iff (porRst)
        settled |-> !pinOeN[1] && runLen_r <= 8'(CLK_DIV))
        else $error("divided clock stalled or released");
    divclk_period_a: assert property (
        @(posedge clk) disable iff (porRst)
        settled && pinDrive[1] != prevDrive_r |-> runLen_r == 8'(CLK_DIV))
        else $error("divided clock half period wrong");
    pin_inputs_a: assert property (
        pinsQuiet |-> pinChangeIrq == pinIn &&
        externalInterruptZero == pinIn[6] && timer1CaptureIn == pinIn[4] &&
        powerStageIn0 == pinIn[1] && powerStageIn2 == pinIn[2])
        else $error("forwarded pin level wrong");
    psc_out_a: assert property (
        powerStageEnable0a |=> !pinOeN[0] &&
        pinDrive[0] == $past(powerStageOut0a))
        else $error("power stage output not on pin 0");
endmodule

bind pdaf_override pdaf_override_chk #(.CLK_DIV(CLK_DIV)) i_chk (.*);
`default_nettype wire

// File: tb/pdaf_board_model.sv
// Board-side model that resolves each port D pin from all its drivers.
`timescale 1ns/1ps
`default_nettype none

module pdaf_board_model (
    // Clock
    input  wire logic                clk,
    // Device side
    input  wire pdaf_pkg::pdaf_pin_t pinDrive,
    input  wire pdaf_pkg::pdaf_pin_t pinOeN,
    input  wire pdaf_pkg::pdaf_pin_t pullUpEnable,
    // Board drivers
    input  wire pdaf_pkg::pdaf_pin_t extDrive,
    input  wire pdaf_pkg::pdaf_pin_t extEn,
    // Resolved levels
    output var  pdaf_pkg::pdaf_pin_t pinIn
);
    import pdaf_pkg::*;
    // A floating pin wanders every cycle so nothing can lean on it.
    logic floatPat_r = 1'b0;
    always_ff @(posedge clk) begin
        floatPat_r <= ~floatPat_r;
    end
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pinOeN[i])
                pinIn[i] = pinDrive[i];
            else if (extEn[i])
                pinIn[i] = extDrive[i];
            else
                pinIn[i] = pullUpEnable[i] | floatPat_r;
        end
    end
endmodule
`default_nettype wire

// File: tb/tb_port_d_alt_function_override.sv
// Self-checking bench for the port D alternate-function override block.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(act, exp) begin \
    checked++; \
    if ((act) !== (exp)) begin \
        errors++; \
        $display("wrong value at %0t got %h expected %h", $time, act, exp); \
    end \
end

module tb_port_d_alt_function_override;
    import pdaf_pkg::*;
    localparam int CLK_DIV = 2;
    typedef struct packed {
        pdaf_pin_t dir, out;
        logic [15:0] ctl;
        pdaf_pin_t oeN, drv, pu;
    } pdaf_row_t;
    logic clk, rst, porRst, clockOutputFuse;
    logic [15:0] ctl;
    logic [7:0] n;
    int errors = 0, checked = 0, cycles = 0;
    pdaf_pin_t directionBits, outBits, extDrive, extEn, pinIn, pinDrive;
    pdaf_pin_t pinOeN, pullUpEnable, pinValue, pinChangeIrq;
    logic externalInterruptZero, timer1CaptureIn, uartRxData;
    logic spiSlaveSelectN, spiSlaveActive, spiMasterOutIn, spiClockIn;
    logic spiMasterIn, powerStageIn0, powerStageIn2;
    wire logic pullUpDisable = ctl[0], uartRxEnable = ctl[1];
    wire logic uartTxEnable = ctl[2], uartTxData = ctl[3];
    wire logic spiEnable = ctl[4], spiMaster = ctl[5], spiAltPins = ctl[6];
    wire logic spiMasterOutData = ctl[7], spiClockOut = ctl[8];
    wire logic spiSlaveOutData = ctl[9], timer0CompareEnable = ctl[10];
    wire logic timer0CompareAOut = ctl[11], timer1CompareEnable = ctl[12];
    wire logic timer1CompareAOut = ctl[13], powerStageEnable0a = ctl[14];
    wire logic powerStageOut0a = ctl[15];
    // Columns: direction, output, controls, then expected enable, drive, pull.
    pdaf_row_t rows [8] = '{
        '{8'h18, 8'h10, 16'h000E, 8'hF7, 8'h08, 8'h10},
        '{8'h0C, 8'h00, 16'hFC00, 8'hF2, 8'h0D, 8'h00},
        '{8'h00, 8'h00, 16'h3C00, 8'hFF, 8'h00, 8'h00},
        '{8'h1C, 8'h18, 16'h0250, 8'hFB, 8'h04, 8'h18},
        '{8'h1C, 8'h18, 16'h0251, 8'hFB, 8'h04, 8'h00},
        '{8'h1C, 8'h04, 16'h01F0, 8'hE7, 8'h18, 8'h04},
        '{8'h00, 8'h00, 16'h01F0, 8'hFF, 8'h00, 8'h00},
        '{8'hA5, 8'hF0, 16'h0000, 8'h5A, 8'hA0, 8'h50}};
    pdaf_pin_t pats [2] = '{8'h4B, 8'hB4};

    pdaf_override #(.CLK_DIV(CLK_DIV)) i_dut (.*);
    pdaf_board_model i_board (.*);

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic countToggles(input int len, output logic [7:0] cnt);
        logic prev;
        cnt = 8'h00;
        @(negedge clk);
        prev = pinDrive[1];
        repeat (len) begin
            @(negedge clk);
            if (pinDrive[1] !== prev) cnt++;
            prev = pinDrive[1];
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // A hang costs a mismatch; the whole run needs about 120 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            errors++;
            tally_and_finish();
        end
    end

    initial begin
        {rst, porRst, clockOutputFuse} = 3'b110;
        {directionBits, outBits, extDrive, extEn} = 32'h0000_0000;
        ctl = 16'h0000;
        repeat (20) @(posedge clk);
        @(negedge clk);
        `CHECK({pinOeN, pinDrive, pullUpEnable}, 24'hFF0000)
        `CHECK({uartRxData, spiSlaveSelectN, pinChangeIrq}, 10'h300)
        @(posedge clk);
        {rst, porRst} <= 2'b00;
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge clk);
            directionBits <= rows[i].dir;
            outBits <= rows[i].out;
            ctl <= rows[i].ctl;
            @(posedge clk);
            @(negedge clk);
            `CHECK(pinOeN, rows[i].oeN)
            `CHECK(pinDrive & ~rows[i].oeN, rows[i].drv)
            `CHECK(pullUpEnable, rows[i].pu)
        end
        $display("test override table done");
        // Comparator pins stay inputs without pull-up here.
        @(posedge clk);
        {directionBits, outBits, extEn} <= 24'h0000FF;
        ctl <= 16'h0050;
        foreach (pats[i]) begin
            @(posedge clk);
            extDrive <= pats[i];
            repeat (6) @(posedge clk);
            @(negedge clk);
            `CHECK(pinChangeIrq, pats[i])
            `CHECK(externalInterruptZero, pats[i][6])
            `CHECK({timer1CaptureIn, uartRxData}, {2{pats[i][4]}})
            `CHECK({powerStageIn2, powerStageIn0}, pats[i][2:1])
            `CHECK(pinValue, pats[i])
            `CHECK(spiSlaveSelectN, pats[i][3])
            `CHECK(spiMasterOutIn, pats[i][3])
            `CHECK(spiClockIn, pats[i][4])
            `CHECK(spiMasterIn, pats[i][2])
            `CHECK(spiSlaveActive, ~pats[i][3])
        end
        $display("test pin inputs done");
        @(posedge clk);
        extEn <= 8'h00;
        ctl <= 16'h0000;
        clockOutputFuse <= 1'b1;
        repeat (4) @(posedge clk);
        countToggles(40, n);
        `CHECK(n, 8'(40 / CLK_DIV))
        `CHECK(pinOeN[1], 1'b0)
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        countToggles(12, n);
        `CHECK(n, 8'(12 / CLK_DIV))
        `CHECK(pinOeN[1], 1'b0)
        // With the fuse cleared, pin 1 must fall back to floating in reset.
        @(posedge clk);
        clockOutputFuse <= 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        `CHECK({pinOeN[1], pinDrive[1]}, 2'b10)
        @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        $display("test clock output done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
